/* File: bench/adr_bus_master.sv */
/*
 * Two-wire bus master model that reaches the register bank.
 * Assumes a pull-up on the data line; the bank pulls it low through its enable.
 */
`default_nettype none

module adr_bus_master
    import adr_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic sda_line,
    output var  logic scl_pin,
    output var  logic sda_low
);
    timeunit 1ns;
    timeprecision 1ns;

    // Bus idles released, the pull-up holds data high
    initial begin
        scl_pin = 1'b1;
        sda_low = 1'b0;
    end

    // Ten clocks a phase, clear of the eight the pin filters need
    task automatic phase();
        repeat (10) @(negedge clk_sys);
    endtask

    // Start or repeated start: data falls while the clock is high
    task automatic start();
        sda_low = 1'b0;
        phase();
        scl_pin = 1'b1;
        phase();
        sda_low = 1'b1;
        phase();
        scl_pin = 1'b0;
        phase();
    endtask

    task automatic stop();
        sda_low = 1'b1;
        phase();
        scl_pin = 1'b1;
        phase();
        sda_low = 1'b0;
        phase();
    endtask

    // Data set a full phase after the clock fell, so it never races the fall
    task automatic put_bit(input logic b, output logic s);
        sda_low = ~b;
        phase();
        scl_pin = 1'b1;
        phase();
        s = sda_line;
        scl_pin = 1'b0;
        phase();
    endtask

    // Whole bytes, MSB first, ninth bit returned as sampled
    task automatic send(input logic [7:0] b, output logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) put_bit(b[i], s);
        put_bit(1'b1, nack);
    endtask

    task automatic recv(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) put_bit(1'b1, b[i]);
        put_bit(last, s);
    endtask

    // Only documented sub-addresses are passed in by the bench
    task automatic write_regs(input logic [6:0] dev, input logic [7:0] sub, input logic [7:0] d[$],
                              output logic nack);
        logic n;
        start();
        send({dev, 1'b0}, nack);
        send(sub, n);
        nack |= n;
        foreach (d[i]) begin
            send(d[i], n);
            nack |= n;
        end
        stop();
    endtask

    task automatic read_regs(input logic [7:0] sub, input int cnt, output logic [7:0] q[$]);
        logic n;
        logic [7:0] b;
        q = {};
        start();
        send({ADR_DEV_ADDR, 1'b0}, n);
        send(sub, n);
        start();
        send({ADR_DEV_ADDR, 1'b1}, n);
        for (int i = 0; i < cnt; i++) begin
            recv(i == cnt - 1, b);
            q.push_back(b);
        end
        stop();
    endtask
endmodule

`default_nettype wire

/* File: bench/adr_register_bank_asserts.sv */
/*
 * Concurrent checks on the ports of the audio decoder register bank.
 * Assumes one system clock and an active-high asynchronous reset.
 */
`default_nettype none

module adr_register_bank_asserts
    import adr_pkg::*;
(
    input  wire logic           clk_sys,
    input  wire logic           sys_rst,
    input  wire logic           scl_pin,
    input  wire logic           sda_pin_in,
    input  wire logic           sda_pin_out,
    input  wire logic           sda_pin_oe,
    input  wire adr_status_type status,
    input  wire adr_clkctl_type clk_ctrl,
    input  wire adr_bank_type   ctrl_bank,
    input  wire logic           fraction_load_strobe,
    input  wire logic           req_active_high,
    input  wire logic           soft_reset_pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // Open drain: the data pin may only ever be pulled low
    a_sda_open_drain: assert property (sda_pin_out == 1'b0)
        else $error("data pin driven high");
    // Device changes the data line only while the bus clock is low
    a_oe_scl_low: assert property ($changed(sda_pin_oe) |-> !scl_pin)
        else $error("data line moved while bus clock high");
    a_frac_single: assert property (fraction_load_strobe |=> (!fraction_load_strobe) [*8])
        else $error("fraction load strobe repeated");
    a_frac_needs_bit: assert property (fraction_load_strobe |-> clk_ctrl.fraction_load_strobe)
        else $error("fraction load without bit zero");
    a_reset_values: assert property ($fell(sys_rst) |-> clk_ctrl == ADR_CLKCTL_RESET && req_active_high)
        else $error("clock control reset value wrong");
    // Two stable cycles so a registered copy has caught up
    a_req_follows_reg: assert property (
        $past(ctrl_bank[ADR_SLOT_REQUEST_LINE_POLARITY]) == ctrl_bank[ADR_SLOT_REQUEST_LINE_POLARITY]
        && $past(ctrl_bank[ADR_SLOT_REQUEST_LINE_POLARITY], 2) == ctrl_bank[ADR_SLOT_REQUEST_LINE_POLARITY]
        |-> req_active_high == !ctrl_bank[ADR_SLOT_REQUEST_LINE_POLARITY][ADR_BIT_REQ_INV])
        else $error("request polarity output disagrees with register");
    a_masked_bits: assert property (ctrl_bank[12][7:2] == 6'h0 && ctrl_bank[13][7:1] == 7'h0
        && ctrl_bank[17][7:4] == 4'h0)
        else $error("bits above useful size set");
    // Registers only change just after a bus clock fall, never mid high phase
    a_idle_stable: assert property ((scl_pin) [*8] |-> $stable(clk_ctrl) && $stable(ctrl_bank))
        else $error("register changed while bus clock high");
endmodule

bind adr_register_bank adr_register_bank_asserts adr_register_bank_asserts_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .scl_pin(scl_pin), .sda_pin_in(sda_pin_in),
    .sda_pin_out(sda_pin_out), .sda_pin_oe(sda_pin_oe), .status(status), .clk_ctrl(clk_ctrl),
    .ctrl_bank(ctrl_bank), .fraction_load_strobe(fraction_load_strobe),
    .req_active_high(req_active_high), .soft_reset_pulse(soft_reset_pulse));

`default_nettype wire

/* File: bench/tb_adr_register_bank.sv */
/*
 * Self-checking bench for the register bank, driven through the bus model.
 * Assumes the bus model's tasks and a pull-up on the data line.
 */
`default_nettype none

module tb_adr_register_bank;
    timeunit 1ns;
    timeprecision 1ns;
    import adr_pkg::*;

    localparam logic [7:0] REV = 8'h27;   // Arbitrary value
    localparam logic [7:0] IDC = 8'h3c;   // Arbitrary value

    logic           clk_sys = 1'b0;
    logic           sys_rst = 1'b1;
    logic           scl_pin, sda_low, sda_line, sda_pin_out, sda_pin_oe;
    logic           frac_strobe, req_hi, soft_pulse, n;
    adr_status_type status;
    adr_clkctl_type clk_ctrl;
    adr_bank_type   ctrl_bank;
    logic [7:0]     v;
    logic [7:0]     q[$];
    int             mismatches, samples_checked, cycles, frac_count, soft_count;

    // Wired-AND data line with pull-up
    assign sda_line = ~(sda_low | sda_pin_oe);

    adr_register_bank #(.REVISION_CODE(REV), .IDENT_CODE(IDC)) adr_register_bank_inst (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .scl_pin(scl_pin), .sda_pin_in(sda_line),
        .sda_pin_out(sda_pin_out), .sda_pin_oe(sda_pin_oe), .status(status), .clk_ctrl(clk_ctrl),
        .ctrl_bank(ctrl_bank), .fraction_load_strobe(frac_strobe), .req_active_high(req_hi),
        .soft_reset_pulse(soft_pulse));

    adr_bus_master adr_bus_master_inst (
        .clk_sys(clk_sys), .sda_line(sda_line), .scl_pin(scl_pin), .sda_low(sda_low));

    always #20 clk_sys = ~clk_sys;

    // Pulse counters and the hang limit, about two fifths above the expected run
    always @(posedge clk_sys) begin
        cycles++;
        if (frac_strobe === 1'b1) frac_count++;
        if (soft_pulse === 1'b1) soft_count++;
        if (cycles == 90000) begin
            mismatches++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (mismatches == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [7:0] sub, output logic [7:0] b);
        logic [7:0] r[$];
        adr_bus_master_inst.read_regs(sub, 1, r);
        b = r[0];
    endtask

    // Single-byte write; every byte must be acknowledged
    task automatic wr(input logic [7:0] sub, input logic [7:0] b);
        logic [7:0] d[$];
        logic       k;
        d = {b};
        adr_bus_master_inst.write_regs(ADR_DEV_ADDR, sub, d, k);
        check8({7'h0, k}, 8'h00);
    endtask

    initial begin
        status = '0;
        status.fault_code = 8'h2c;
        status.lock_state = 8'h02;
        repeat (12) @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (10) @(negedge clk_sys);
        // Reset values of the read-write bank
        for (int i = 0; i < ADR_NRW; i++) begin
            rd(ADR_RW_ADDR[i], v);
            check8(v, ADR_RW_RESET[i]);
        end
        rd(ADR_CLKCTL, v);
        check8(v, 8'ha1);
        rd(ADR_REVISION, v);
        check8(v, REV);
        // Read-only places ignore writes
        wr(ADR_IDENT, 8'h00);
        rd(ADR_IDENT, v);
        check8(v, IDC);
        wr(ADR_FAULT, 8'hff);
        rd(ADR_FAULT, v);
        check8(v, 8'h2c);
        // Walk a single one through every clock control bit
        for (int i = 0; i < 8; i++) begin
            wr(ADR_CLKCTL, 8'h01 << i);
            check8(clk_ctrl, 8'h01 << i);
        end
        check8(frac_count[7:0], 8'h01);
        wr(8'h0c, 8'h05);
        check8({7'h0, req_hi}, 8'h00);
        wr(8'h0c, 8'h01);
        check8({7'h0, req_hi}, 8'h01);
        // Three bytes in one transfer land at consecutive places
        q = {8'h12, 8'h34, 8'h56};
        adr_bus_master_inst.write_regs(ADR_DEV_ADDR, 8'h46, q, n);
        adr_bus_master_inst.read_regs(8'h46, 3, q);
        check8(q[0], 8'h12);
        check8(q[1], 8'h34);
        check8(q[2], 8'h56);
        wr(8'h4d, 8'hff);
        rd(8'h4d, v);
        check8(v, 8'h03);
        // Software reset clears the command places only
        wr(8'h16, 8'h01);
        wr(ADR_SOFT_RESET, 8'h01);
        check8(soft_count[7:0], 8'h01);
        rd(8'h16, v);
        check8(v, 8'h00);
        rd(ADR_SOFT_RESET, v);
        check8(v, 8'h00);
        // A foreign device address is neither acknowledged nor obeyed
        q = {8'hee};
        adr_bus_master_inst.write_regs(7'h42, 8'h46, q, n);
        check8({7'h0, n}, 8'h01);
        rd(8'h46, v);
        check8(v, 8'h12);
        rd(ADR_SYNC, v);
        check8(v, 8'h02);
        print_verdict();
    end
endmodule

`default_nettype wire

/* File: hw/adr_register_bank.sv */
/*
 * Register bank of the audio decoder with its two-wire bus slave.
 * Assumes the bus pins are asynchronous, the data pin is open drain and is
 * resolved outside, and decoder status arrives on the system clock.
 * Bus clock phases must last eight clocks or more.
 * No clock stretching; the address is fixed.
 * The voice window is not modelled here.
 * Unmapped places read zero.
 * Writes to them are acknowledged and dropped.
 */
`default_nettype none

module adr_register_bank
    import adr_pkg::*;
#(
    parameter logic [7:0] REVISION_CODE = 8'h11,   // Arbitrary value
    parameter logic [7:0] IDENT_CODE    = 8'h5a    // Arbitrary value
) (
    input  wire logic           clk_sys,
    input  wire logic           sys_rst,
    input  wire logic           scl_pin,
    input  wire logic           sda_pin_in,
    output var  logic           sda_pin_out,
    output var  logic           sda_pin_oe,
    input  wire adr_status_type status,
    output var  adr_clkctl_type clk_ctrl,
    output var  adr_bank_type   ctrl_bank,
    output var  logic           fraction_load_strobe,
    output var  logic           req_active_high,
    output var  logic           soft_reset_pulse
);

    // Finds the bank slot of a sub-address
    // All ones: no storage here
    // A new slot needs only a table entry
    function automatic logic [5:0] slot_of(input logic [7:0] addr);
        logic [5:0] hit;
        hit = 6'h3f;
        for (int i = 0; i < ADR_NRW; i++) begin
            if (ADR_RW_ADDR[i] == addr) begin
                hit = 6'(i);
            end
        end
        return hit;
    endfunction

    // Pin filter and bus events
    logic [2:0]    scl_sync;
    logic [2:0]    sda_sync;
    logic          scl_level;
    logic          sda_level;
    logic          scl_prev;
    logic          sda_prev;
    logic          scl_rise;
    logic          scl_fall;
    logic          bus_start;
    logic          bus_stop;

    // Slave sequence
    adr_state_type state;
    logic [3:0]    bit_cnt;
    logic [7:0]    shift_in;
    logic [7:0]    shift_out;
    logic [7:0]    sub_ptr;
    logic          read_mode;

    // Decoded events
    logic          byte_done;
    logic          ack_done;
    logic          wr_fire;
    logic [7:0]    rd_value;
    logic [5:0]    wr_slot;
    logic [5:0]    rd_slot;

    // Three flops per pin; the first is read only by the second
    // Reset high: no false edge
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
        end else begin
            scl_sync <= {scl_sync[1:0], scl_pin};
            sda_sync <= {sda_sync[1:0], sda_pin_in};
        end
    end

    // A level counts once the second and third flops agree
    // Glitches of one clock are dropped
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            scl_level <= 1'b1;
            sda_level <= 1'b1;
        end else begin
            if (scl_sync[1] == scl_sync[2]) begin
                scl_level <= scl_sync[2];
            end
            if (sda_sync[1] == sda_sync[2]) begin
                sda_level <= sda_sync[2];
            end
        end
    end

    // Previous filtered levels for edge detection
    // Reset to the idle pin level
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_prev <= scl_level;
            sda_prev <= sda_level;
        end
    end

    // Bus events; data moving while the clock is high marks start or stop
    // Both need the clock high
    // Stop idles the slave in mid byte
    assign scl_rise  = scl_level & ~scl_prev;
    assign scl_fall  = ~scl_level & scl_prev;
    assign bus_start = scl_level & scl_prev & sda_prev & ~sda_level;
    assign bus_stop  = scl_level & scl_prev & ~sda_prev & sda_level;

    // Falling edge closing the eighth data bit, and the one closing the ack slot
    // A fall leaves a low phase for setup
    // The ack slot ends after the ninth rise
    assign byte_done = scl_fall & (bit_cnt == 4'd8);
    assign ack_done  = scl_fall & (bit_cnt == 4'd9);
    assign wr_fire   = byte_done & (state == ADR_WRITE);
    assign wr_slot   = slot_of(sub_ptr);
    assign rd_slot   = slot_of(sub_ptr);

    // Read data for the current sub-address; unmapped and write-only read zero
    // Status is shown live
    // Unmapped places never show stale data
    always_comb begin
        rd_value = 8'h00;
        unique case (sub_ptr)
            ADR_REVISION:    rd_value = REVISION_CODE;
            ADR_IDENT:       rd_value = IDENT_CODE;
            ADR_CLKCTL:      rd_value = clk_ctrl;
            ADR_FAULT:       rd_value = status.fault_code;
            ADR_SYNC:        rd_value = status.lock_state;
            ADR_ANC_LOW:     rd_value = status.side_bits_count[7:0];
            ADR_ANC_HIGH:    rd_value = status.side_bits_count[15:8];
            ADR_HEAD_UPPER:  rd_value = status.frame_header[23:16];
            ADR_HEAD_MIDDLE: rd_value = status.frame_header[15:8];
            ADR_HEAD_LOWER:  rd_value = status.frame_header[7:0];
            ADR_FRAMES_LOW:  rd_value = status.frames_decoded[7:0];
            ADR_FRAMES_MID:  rd_value = status.frames_decoded[15:8];
            ADR_FRAMES_HIGH: rd_value = status.frames_decoded[23:16];
            ADR_MEAN_RATE:   rd_value = status.mean_rate;
            ADR_FW_REVISION: rd_value = status.firmware_revision;
            default: begin
                if (rd_slot != 6'h3f) begin
                    rd_value = ctrl_bank[rd_slot[4:0]];
                end
            end
        endcase
    end

    // Slave sequence: select, sub-address, then data bytes until stop
    // A start wins, even in mid byte
    // A read nack idles until next start
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state     <= ADR_IDLE;
            read_mode <= 1'b0;
        end else if (bus_start) begin
            state <= ADR_DEVSEL;                                               // Repeated start too
        end else if (bus_stop) begin
            state <= ADR_IDLE;
        end else if (byte_done && state == ADR_DEVSEL) begin
            if (shift_in[7:1] == ADR_DEV_ADDR) begin
                read_mode <= shift_in[0];
            end else begin
                state <= ADR_IDLE;                                             // Not ours: wait for start
            end
        end else if (scl_rise && bit_cnt == 4'd8 && state == ADR_READ && sda_level) begin
            state <= ADR_IDLE;                                                 // Master refused more data
        end else if (ack_done) begin
            unique case (state)
                ADR_DEVSEL:  state <= read_mode ? ADR_READ : ADR_SUBADDR;
                ADR_SUBADDR: state <= ADR_WRITE;
                default:     state <= state;
            endcase
        end
    end

    // Bit counter: 0..7 data bits, 8 ack slot, 9 ack slot done
    // Idle holds zero: no stray byte ends
    // At a fall it names the bit about to start
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            bit_cnt <= 4'd0;
        end else if (bus_start || bus_stop || state == ADR_IDLE) begin
            bit_cnt <= 4'd0;
        end else if (ack_done) begin
            bit_cnt <= 4'd0;
        end else if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'd1;
        end
    end

    // Incoming bits are sampled on the clock's rising edge, MSB first
    // Ack slot is not shifted
    // Filtered level: four clocks late
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            shift_in <= 8'h00;
        end else if (scl_rise && bit_cnt < 4'd8) begin
            shift_in <= {shift_in[6:0], sda_level};
        end
    end

    // Sub-address counter steps after every byte written or read
    // Wraps at the top
    // Read moves it when a byte is latched
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sub_ptr <= 8'h00;
        end else if (byte_done && state == ADR_SUBADDR) begin
            sub_ptr <= shift_in;
        end else if (wr_fire) begin
            sub_ptr <= sub_ptr + 8'h01;
        end else if (ack_done && state == ADR_READ) begin
            sub_ptr <= sub_ptr + 8'h01;
        end else if (ack_done && state == ADR_DEVSEL && read_mode) begin
            sub_ptr <= sub_ptr + 8'h01;
        end
    end

    // Byte to send is captured as the ack slot ends, so later writes cannot tear it
    // Limitation: counters may tear
    // across bytes of one multi-byte read
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            shift_out <= 8'h00;
        end else if (ack_done && (state == ADR_READ || (state == ADR_DEVSEL && read_mode))) begin
            shift_out <= rd_value;
        end
    end

    // Open-drain data pin: only ever pulled low, released otherwise
    // Changes come five clocks after a fall,
    // so data never moves with clock high
    // Start and stop release the line
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sda_pin_out <= 1'b0;
            sda_pin_oe  <= 1'b0;
        end else begin
            sda_pin_out <= 1'b0;
            if (bus_start || bus_stop) begin
                sda_pin_oe <= 1'b0;
            end else if (byte_done) begin
                // Acknowledge our select and every byte we receive
                sda_pin_oe <= (state == ADR_DEVSEL && shift_in[7:1] == ADR_DEV_ADDR) ||
                              state == ADR_SUBADDR || state == ADR_WRITE;
            end else if (ack_done) begin
                if (state == ADR_READ || (state == ADR_DEVSEL && read_mode)) begin
                    sda_pin_oe <= ~rd_value[7];
                end else begin
                    sda_pin_oe <= 1'b0;
                end
            end else if (scl_fall && state == ADR_READ && bit_cnt < 4'd8) begin
                sda_pin_oe <= ~shift_out[3'(4'd7 - bit_cnt)];
            end
        end
    end

    // Clock generator control; each field above bit zero steers the clock tree directly
    // Reset: bits seven, five, zero set
    // No side effect beyond the strobe
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            clk_ctrl <= adr_clkctl_type'(ADR_CLKCTL_RESET);
        end else if (wr_fire && sub_ptr == ADR_CLKCTL) begin
            clk_ctrl <= adr_clkctl_type'(shift_in);
        end
    end

    // Fraction update is a one-cycle pulse to the clock switch on each loading write
    // Stored bit alone does not reload
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            fraction_load_strobe <= 1'b0;
        end else begin
            fraction_load_strobe <= wr_fire && sub_ptr == ADR_CLKCTL &&
                                    shift_in[ADR_BIT_FRAC_LOAD];
        end
    end

    // Plain read-write bank, one generate branch per slot
    // Flops cost area, reads are at once
    // Masks keep unused bits at zero
    generate
        for (genvar g = 0; g < ADR_NRW; g++) begin : g_bank
            always_ff @(posedge clk_sys or posedge sys_rst) begin
                if (sys_rst) begin
                    ctrl_bank[g] <= ADR_RW_RESET[g];
                end else if (wr_fire && wr_slot == 6'(g)) begin
                    // Bits beyond the register's useful size stay zero
                    ctrl_bank[g] <= shift_in & ADR_RW_MASK[g];
                end else if (soft_reset_pulse && (g == ADR_SLOT_REFRESH || g == ADR_SLOT_GO)) begin
                    // Soft reset clears the command registers and idles the decoder
                    // A write in the same clock wins
                    ctrl_bank[g] <= ADR_RW_RESET[g];
                end
            end
        end
    endgenerate

    // Read-only and unmapped locations have no storage, so writes fall away
    // Such a write still gets its ack

    // Soft reset fires on any write to its location, whatever the data
    // One clock wide
    // Any data counts, zero too
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            soft_reset_pulse <= 1'b0;
        end else begin
            soft_reset_pulse <= wr_fire && sub_ptr == ADR_SOFT_RESET;
        end
    end

    // Request level: high by default, low once the invert bit is written
    // Registered: no glitch on writes
    // Only bit two matters
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            req_active_high <= 1'b1;
        end else begin
            req_active_high <= ~ctrl_bank[ADR_SLOT_REQUEST_LINE_POLARITY][ADR_BIT_REQ_INV];
        end
    end

endmodule

`default_nettype wire

/* File: shared/adr_pkg.sv */
/*
 * Constants, types and register map of the audio decoder register bank.
 * Assumes one system clock; the two-wire bus pins arrive asynchronously.
 */
// Contract
// - Every register is eight bits; only whole-byte reads and writes are made.
// - Registers without reset value hold undefined content after reset.
// - Read-only revision register sits at sub-address zero.
// - Read-only identification register at sub-address one returns a fixed code.
// - Clock control bit 0 loads the new fraction into the clock switch.
// - Clock control bit 1 feeds the output-clock divider from the crystal.
// - Clock control bit 2 feeds the processor-clock divider from the crystal.
// - Clock control bit 3 disables the oscillator output.
// - Clock control bit 4 puts the system clock on the output-clock pin.
// - Clock control bit 5 enables the output-clock pad as output.
// - Clock control bit 6 disables the crystal output pad.
// - Clock control bit 7 enables the shared buffered-clock or request pin.
// - Multiplier and input-divider registers are read-write, owned by firmware.
// - Request polarity: value one sends while high, bit two inverts it.
// - Sub-address counter increments after every byte read or written.
// - Device answers only to its fixed seven-bit bus address.
`default_nettype none

package adr_pkg;

    // Two-wire bus slave address
    localparam logic [6:0] ADR_DEV_ADDR      = 7'h43;

    // Sub-addresses served by dedicated logic
    localparam logic [7:0] ADR_REVISION      = 8'h00;
    localparam logic [7:0] ADR_IDENT         = 8'h01;
    localparam logic [7:0] ADR_CLKCTL        = 8'h05;
    localparam logic [7:0] ADR_FAULT         = 8'h0f;
    localparam logic [7:0] ADR_SOFT_RESET    = 8'h10;
    localparam logic [7:0] ADR_SYNC          = 8'h40;
    localparam logic [7:0] ADR_ANC_LOW       = 8'h41;
    localparam logic [7:0] ADR_ANC_HIGH      = 8'h42;
    localparam logic [7:0] ADR_HEAD_UPPER    = 8'h43;
    localparam logic [7:0] ADR_HEAD_MIDDLE   = 8'h44;
    localparam logic [7:0] ADR_HEAD_LOWER    = 8'h45;
    localparam logic [7:0] ADR_FRAMES_LOW    = 8'h67;
    localparam logic [7:0] ADR_FRAMES_MID    = 8'h68;
    localparam logic [7:0] ADR_FRAMES_HIGH   = 8'h69;
    localparam logic [7:0] ADR_MEAN_RATE     = 8'h6a;
    localparam logic [7:0] ADR_FW_REVISION   = 8'h71;

    // Clock generator control reset value and bit positions
    localparam logic [7:0] ADR_CLKCTL_RESET  = 8'ha1;
    localparam int         ADR_BIT_FRAC_LOAD = 0;
    localparam int         ADR_BIT_REQ_INV   = 2;

    // Plain read-write bank: slot order, reset values and useful-bit masks
    localparam int         ADR_NRW           = 30;
    localparam int         ADR_SLOT_REQUEST_LINE_POLARITY  = 2;
    localparam int         ADR_SLOT_REFRESH  = 6;
    localparam int         ADR_SLOT_GO       = 25;
    localparam logic [7:0] ADR_RW_ADDR [ADR_NRW] = '{
        8'h06, 8'h07, 8'h0c, 8'h0d, 8'h13, 8'h14, 8'h16, 8'h18, 8'h46, 8'h47,
        8'h48, 8'h49, 8'h4d, 8'h4e, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55,
        8'h56, 8'h61, 8'h63, 8'h64, 8'h65, 8'h72, 8'h77, 8'h78, 8'h79, 8'h7a};
    localparam logic [7:0] ADR_RW_RESET [ADR_NRW] = '{
        8'h0c, 8'h00, 8'h01, 8'h04, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff,
        8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h21,
        8'h00, 8'h07, 8'h00, 8'h46, 8'h5b, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] ADR_RW_MASK [ADR_NRW] = '{
        8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
        8'hff, 8'hff, 8'h03, 8'h01, 8'hff, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff,
        8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};

    typedef logic [ADR_NRW-1:0][7:0] adr_bank_type;

    // Clock generator control, bit 7 down to bit 0
    typedef struct packed {
        logic buffered_clock_pin_enable;
        logic crystal_out_pad_disable;
        logic outclock_pad_enable;
        logic system_clock_on_outpin;
        logic oscillator_output_disable;
        logic crystal_to_core_divider;
        logic crystal_to_outclk_divider;
        logic fraction_load_strobe;
    } adr_clkctl_type;

    // Decoder state shown through the read-only registers
    typedef struct packed {
        logic [7:0]  fault_code;
        logic [7:0]  lock_state;
        logic [15:0] side_bits_count;
        logic [23:0] frame_header;
        logic [23:0] frames_decoded;
        logic [7:0]  mean_rate;
        logic [7:0]  firmware_revision;
    } adr_status_type;

    // Two-wire slave states
    typedef enum logic [2:0] {
        ADR_IDLE    = 3'b000,
        ADR_DEVSEL  = 3'b001,
        ADR_SUBADDR = 3'b010,
        ADR_WRITE   = 3'b011,
        ADR_READ    = 3'b100
    } adr_state_type;

endpackage

`default_nettype wire
